/* design/baseband_cfg_controller.sv */
// medium access controller end: wishbone registers that issue control bus accesses
`timescale 1ns/10ps
module baseband_cfg_controller
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  baseband_cfg_if.controller bus,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [5:0]  addr;
    logic [7:0]  wdata;
    logic        busy;
    logic [7:0]  rdata;
    logic [1:0]  rate_shadow;
    logic [6:0]  settle_cnt;
    logic        ack;
    logic [31:0] dat_o;
    logic [5:0]  bus_addr;
    logic [7:0]  bus_wdata;
    logic        bus_wr;
    logic        bus_rd;
  } ctl_state_type;

  ctl_state_type q;
  ctl_state_type d;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic [7:0] val;
    d        = q;
    val      = q.wdata;
    d.ack    = 1'b0;
    d.bus_wr = 1'b0;
    d.bus_rd = 1'b0;
    if (q.settle_cnt != 7'h00)
      d.settle_cnt = q.settle_cnt - 7'h01;
    if (q.bus_wr)
      d.busy = 1'b0;
    if (bus.rvalid)
    begin
      d.rdata = bus.rdata;
      d.busy  = 1'b0;
    end

    if (WB_CYC_I && WB_STB_I && !q.ack)
    begin
      d.ack   = 1'b1;
      d.dat_o = 32'h0000_0000;
      if (WB_WE_I && WB_SEL_I[0])
      begin
        case (WB_ADR_I)
          baseband_cfg_pkg::CTL_OFF_ADDR:  d.addr  = WB_DAT_I[5:0];
          baseband_cfg_pkg::CTL_OFF_WDATA: d.wdata = WB_DAT_I[7:0];
          baseband_cfg_pkg::CTL_OFF_CMD:
          begin
            if (!q.busy && WB_DAT_I[baseband_cfg_pkg::CMD_WRITE])
            begin
              case (q.addr)
                baseband_cfg_pkg::OFF_SIGNAL:
                begin
                  val           = q.wdata & ~baseband_cfg_pkg::SIG_ZERO_MASK;
                  d.rate_shadow = val[baseband_cfg_pkg::SIG_RATE_LSB +: 2];
                  d.settle_cnt  = 7'(baseband_cfg_pkg::RATE_SETUP_CYC);
                end
                baseband_cfg_pkg::OFF_SERVICE:
                  val = q.wdata & baseband_cfg_pkg::SVC_KEEP_MASK;
                baseband_cfg_pkg::OFF_TX_CFG:
                begin
                  val[baseband_cfg_pkg::TXC_ZERO] = 1'b0;
                  if (q.rate_shadow != 2'h0)
                    val[baseband_cfg_pkg::TXC_TEST] = 1'b0;
                end
                default:
                  val = q.wdata;
              endcase
              d.busy      = 1'b1;
              d.bus_wr    = 1'b1;
              d.bus_addr  = q.addr;
              d.bus_wdata = val;
            end
            else if (!q.busy && WB_DAT_I[baseband_cfg_pkg::CMD_READ])
            begin
              d.busy     = 1'b1;
              d.bus_rd   = 1'b1;
              d.bus_addr = q.addr;
            end
          end
          default:
            d.addr = q.addr;
        endcase
      end
      else if (!WB_WE_I)
      begin
        case (WB_ADR_I)
          baseband_cfg_pkg::CTL_OFF_ADDR:   d.dat_o = {26'h0, q.addr};
          baseband_cfg_pkg::CTL_OFF_WDATA:  d.dat_o = {24'h0, q.wdata};
          baseband_cfg_pkg::CTL_OFF_STATUS: d.dat_o = {16'h0, q.rdata, 6'h0, (q.settle_cnt == 7'h00), q.busy};
          default:                          d.dat_o = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      q <= '0;
    else
      q <= d;
  end

  assign WB_DAT_O  = q.dat_o;
  assign WB_ACK_O  = q.ack;
  assign bus.addr  = q.bus_addr;
  assign bus.wdata = q.bus_wdata;
  assign bus.wr    = q.bus_wr;
  assign bus.rd    = q.bus_rd;

endmodule : baseband_cfg_controller

/* design/baseband_cfg_if.sv */
// control bus between the medium access controller and the baseband configuration bank
`timescale 1ns/10ps
interface baseband_cfg_if;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       rvalid;

  modport controller (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
  modport device     (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
endinterface : baseband_cfg_if

/* design/baseband_cfg_pkg.sv */
// shared constants and types for the baseband configuration bank and its controller
package baseband_cfg_pkg;

  // ----------------------------------------
  // device bus
  // ----------------------------------------
  localparam int          ADDR_W      = 6;
  localparam int          DATA_W      = 8;
  localparam logic [5:0]  OFF_SIGNAL  = 6'h0a;
  localparam logic [5:0]  OFF_SERVICE = 6'h0c;
  localparam logic [5:0]  OFF_LEN_HI  = 6'h0e;
  localparam logic [5:0]  OFF_LEN_LO  = 6'h10;
  localparam logic [5:0]  OFF_TX_CFG  = 6'h12;
  localparam logic [5:0]  OFF_RX_CFG  = 6'h14;
  localparam logic [5:0]  OFF_TRX_CFG = 6'h16;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0]  RST_SIGNAL  = 8'h00;
  localparam logic [7:0]  RST_SERVICE = 8'h00;
  localparam logic [7:0]  RST_LEN_HI  = 8'h00;
  localparam logic [7:0]  RST_LEN_LO  = 8'h00;
  localparam logic [7:0]  RST_TX_CFG  = 8'h00;
  localparam logic [7:0]  RST_RX_CFG  = 8'h00;
  localparam logic [7:0]  RST_TRX_CFG = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int          SIG_WEIGHT    = 4;
  localparam int          SIG_PREAMBLE  = 3;
  localparam int          SIG_RATE_LSB  = 0;
  localparam logic [7:0]  SIG_ZERO_MASK = 8'he4;
  localparam logic [7:0]  SVC_KEEP_MASK = 8'h84;
  localparam int          TXC_SAMPLE    = 7;
  localparam int          TXC_CCA_LSB   = 5;
  localparam int          TXC_PATTERN   = 4;
  localparam int          TXC_TEST      = 3;
  localparam int          TXC_ANT       = 2;
  localparam int          TXC_DIV       = 1;
  localparam int          TXC_ZERO      = 0;
  localparam int          RXC_FREEZE    = 7;
  localparam int          RXC_CIR_CLK   = 6;
  localparam int          RXC_ISI       = 5;
  localparam int          RXC_ICI       = 4;
  localparam int          RXC_RDY_SFD   = 3;
  localparam int          RXC_SLOT_DIV  = 2;
  localparam int          RXC_ANT       = 1;
  localparam int          RXC_SINGLE    = 0;
  localparam int          TRX_CONT_CLK  = 7;
  localparam int          TRX_SP_TEST   = 4;
  localparam int          TRX_SAMPLED   = 3;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int SLOT_NS         = 20000;
  localparam int SAMPLE_LATE_NS  = 18700;
  localparam int SAMPLE_EARLY_NS = 15800;
  localparam int RATE_SETUP_NS   = 2000;
  localparam int SLOT_CYC        = SLOT_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_LATE_CYC  = (SAMPLE_LATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_EARLY_CYC = (SAMPLE_EARLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RATE_SETUP_CYC  = (RATE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ANT_DWELL_CYC   = 80;
  localparam logic [8:0] PA_RAMP_SYMBOLS = 9'h002;

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  typedef enum logic [1:0] {RATE_1M, RATE_2M, RATE_5M5, RATE_11M} rate_type;
  typedef enum logic [1:0] {MOD_DIFF_BINARY, MOD_DIFF_QUAD, MOD_COMP_CODE} mod_type;
  localparam logic [1:0] CCA_ENERGY   = 2'h0;
  localparam logic [1:0] CCA_CARRIER  = 2'h1;
  localparam logic [1:0] CCA_BOTH     = 2'h2;
  localparam logic [1:0] CCA_EITHER   = 2'h3;
  localparam logic [3:0] CHIPS_BARKER = 4'hb;
  localparam logic [3:0] CHIPS_CODE   = 4'h8;

  // ----------------------------------------
  // controller registers on wishbone
  // ----------------------------------------
  localparam logic [7:0] CTL_OFF_ADDR   = 8'h00;
  localparam logic [7:0] CTL_OFF_WDATA  = 8'h04;
  localparam logic [7:0] CTL_OFF_CMD    = 8'h08;
  localparam logic [7:0] CTL_OFF_STATUS = 8'h0c;
  localparam int         CMD_WRITE      = 0;
  localparam int         CMD_READ       = 1;

endpackage : baseband_cfg_pkg

/* design/baseband_txrx_config_regs.sv */
// baseband transmit/receive configuration register bank, device end
//
// Notes on behaviour
// - weight bit picks standard or channel-14 filters
// - preamble bit picks long or short preamble
// - controller writes zero to unused signal bits
// - rate field selects code, modulation and chips
// - rate written two microseconds before use
// - service top bit may resolve length ambiguity
// - service bit 2 for common oscillator only
// - length is high byte and low byte
// - sample bit picks 18.7 or 15.8 us
// - assessment mode combines energy and carrier detectors
// - test pattern alternating bits or all ones
// - test needs rate zero and scrambler setup
// - transmit antenna fixed or last good header
// - gain freeze holds agc during packet
// - impulse estimate clock during acquisition or after detect
// - equalizer bits enable when zero
// - ready after header check or frame delimiter
// - slot diversity stops switching last half slot
// - single antenna acquisition uses receive choice bit
// - continuous clock bit keeps receive clocks running
// - short preamble test uses long count
// - raw or once-per-slot sampled channel status
// - preamble gets two ramp-up symbols added
`timescale 1ns/10ps
module baseband_txrx_config_regs
(
  input  wire logic                    MCLK,
  input  wire logic                    RST,
  baseband_cfg_if.device               bus,
  input  wire logic                    ENERGY_DETECT,
  input  wire logic                    CARRIER_SENSE_PRIMARY,
  input  wire logic                    SIGNAL_QUALITY_PRIMARY,
  input  wire logic                    SIGNAL_DETECT,
  input  wire logic                    PACKET_ACTIVE,
  input  wire logic                    SFD_SEEN,
  input  wire logic                    HEADER_CRC_OK,
  input  wire logic                    TRANSMIT_POWER_ENABLE,
  input  wire logic                    RECEIVE_POWER_ENABLE,
  input  wire logic [7:0]              SHORT_PREAMBLE_COUNT,
  input  wire logic [7:0]              LONG_PREAMBLE_COUNT,
  output logic                         WEIGHT_SELECT,
  output logic                         SHORT_PREAMBLE_MODE,
  output baseband_cfg_pkg::rate_type   TX_RATE,
  output baseband_cfg_pkg::mod_type    TX_MODULATION,
  output logic [3:0]                   TX_CHIPS_PER_SYMBOL,
  output logic [15:0]                  TX_LENGTH,
  output logic [8:0]                   PREAMBLE_SYMBOLS,
  output logic                         CLEAR_CHANNEL,
  output logic                         TX_TEST_ACTIVE,
  output logic                         TX_TEST_CHIP,
  output logic                         ANTENNA_SELECT_OUT,
  output logic                         AGC_FREEZE,
  output logic                         CIR_CLOCK_EN,
  output logic                         RX_CLOCK_EN,
  output logic                         ISI_EQ_EN,
  output logic                         ICI_EQ_EN,
  output logic                         RX_DATA_READY_OUT,
  output logic                         ACQ_DIVERSITY_ON
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]                 sig;
    logic [7:0]                 svc;
    logic [7:0]                 len_hi;
    logic [7:0]                 len_lo;
    logic [7:0]                 txc;
    logic [7:0]                 rxc;
    logic [7:0]                 trx;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic [9:0]                 slot_cnt;
    logic [6:0]                 dwell_cnt;
    logic                       rx_ant;
    logic                       good_ant;
    logic                       weight;
    logic                       short_pre;
    baseband_cfg_pkg::rate_type rate;
    baseband_cfg_pkg::mod_type  modu;
    logic [3:0]                 chips;
    logic [15:0]                length;
    logic [8:0]                 pre_syms;
    logic                       cca;
    logic                       test_on;
    logic                       test_chip;
    logic                       ant_sel;
    logic                       agc_freeze;
    logic                       cir_clk;
    logic                       rx_clk;
    logic                       isi_en;
    logic                       ici_en;
    logic                       rdy;
    logic                       div_on;
  } dev_state_type;

  dev_state_type q;
  dev_state_type d;

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  function automatic logic [7:0] read_reg(input dev_state_type s, input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      baseband_cfg_pkg::OFF_SIGNAL:  v = s.sig;
      baseband_cfg_pkg::OFF_SERVICE: v = s.svc;
      baseband_cfg_pkg::OFF_LEN_HI:  v = s.len_hi;
      baseband_cfg_pkg::OFF_LEN_LO:  v = s.len_lo;
      baseband_cfg_pkg::OFF_TX_CFG:  v = s.txc;
      baseband_cfg_pkg::OFF_RX_CFG:  v = s.rxc;
      baseband_cfg_pkg::OFF_TRX_CFG: v = s.trx;
      default:                       v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic       raw_cca;
    logic [9:0] sample_at;
    logic       late_half;
    logic [1:0] ccam;
    d         = q;
    raw_cca   = 1'b0;
    ccam      = q.txc[baseband_cfg_pkg::TXC_CCA_LSB +: 2];
    late_half = (q.slot_cnt >= 10'(baseband_cfg_pkg::SLOT_CYC / 2));
    sample_at = q.txc[baseband_cfg_pkg::TXC_SAMPLE] ? 10'(baseband_cfg_pkg::SAMPLE_EARLY_CYC - 1)
                                                    : 10'(baseband_cfg_pkg::SAMPLE_LATE_CYC - 1);

    d.rvalid = 1'b0;
    if (bus.wr)
    begin
      case (bus.addr)
        baseband_cfg_pkg::OFF_SIGNAL:  d.sig    = bus.wdata;
        baseband_cfg_pkg::OFF_SERVICE: d.svc    = bus.wdata;
        baseband_cfg_pkg::OFF_LEN_HI:  d.len_hi = bus.wdata;
        baseband_cfg_pkg::OFF_LEN_LO:  d.len_lo = bus.wdata;
        baseband_cfg_pkg::OFF_TX_CFG:  d.txc    = bus.wdata;
        baseband_cfg_pkg::OFF_RX_CFG:  d.rxc    = bus.wdata;
        baseband_cfg_pkg::OFF_TRX_CFG: d.trx    = bus.wdata;
        default:                       d.sig    = q.sig;
      endcase
    end
    if (bus.rd)
    begin
      d.rvalid = 1'b1;
      d.rdata  = read_reg(q, bus.addr);
    end

    // transmit settings
    d.weight    = q.sig[baseband_cfg_pkg::SIG_WEIGHT];
    d.short_pre = q.sig[baseband_cfg_pkg::SIG_PREAMBLE];
    d.rate      = baseband_cfg_pkg::rate_type'(q.sig[baseband_cfg_pkg::SIG_RATE_LSB +: 2]);
    case (d.rate)
      baseband_cfg_pkg::RATE_1M:
      begin
        d.modu  = baseband_cfg_pkg::MOD_DIFF_BINARY;
        d.chips = baseband_cfg_pkg::CHIPS_BARKER;
      end
      baseband_cfg_pkg::RATE_2M:
      begin
        d.modu  = baseband_cfg_pkg::MOD_DIFF_QUAD;
        d.chips = baseband_cfg_pkg::CHIPS_BARKER;
      end
      default:
      begin
        d.modu  = baseband_cfg_pkg::MOD_COMP_CODE;
        d.chips = baseband_cfg_pkg::CHIPS_CODE;
      end
    endcase
    d.length = {q.len_hi, q.len_lo};
    if (q.sig[baseband_cfg_pkg::SIG_PREAMBLE] && !q.trx[baseband_cfg_pkg::TRX_SP_TEST])
      d.pre_syms = {1'b0, SHORT_PREAMBLE_COUNT} + baseband_cfg_pkg::PA_RAMP_SYMBOLS;
    else
      d.pre_syms = {1'b0, LONG_PREAMBLE_COUNT} + baseband_cfg_pkg::PA_RAMP_SYMBOLS;

    // transmit test pattern
    d.test_on = q.txc[baseband_cfg_pkg::TXC_TEST];
    if (!q.txc[baseband_cfg_pkg::TXC_TEST])
      d.test_chip = 1'b0;
    else if (q.txc[baseband_cfg_pkg::TXC_PATTERN])
      d.test_chip = 1'b1;
    else
      d.test_chip = ~q.test_chip;

    // slot timing and channel assessment
    d.slot_cnt = (q.slot_cnt == 10'(baseband_cfg_pkg::SLOT_CYC - 1)) ? 10'h000 : q.slot_cnt + 10'h001;
    case (ccam)
      baseband_cfg_pkg::CCA_ENERGY:  raw_cca = ENERGY_DETECT;
      baseband_cfg_pkg::CCA_CARRIER: raw_cca = CARRIER_SENSE_PRIMARY | SIGNAL_QUALITY_PRIMARY;
      baseband_cfg_pkg::CCA_BOTH:    raw_cca = ENERGY_DETECT & (CARRIER_SENSE_PRIMARY | SIGNAL_QUALITY_PRIMARY);
      default:                       raw_cca = ENERGY_DETECT | CARRIER_SENSE_PRIMARY | SIGNAL_QUALITY_PRIMARY;
    endcase
    if (!q.trx[baseband_cfg_pkg::TRX_SAMPLED])
      d.cca = raw_cca;
    else if (q.slot_cnt == sample_at)
      d.cca = raw_cca;

    // receive antenna diversity and transmit antenna choice
    d.div_on = !q.rxc[baseband_cfg_pkg::RXC_SINGLE] && !(q.rxc[baseband_cfg_pkg::RXC_SLOT_DIV] && late_half);
    if (q.div_on && !SIGNAL_DETECT)
    begin
      if (q.dwell_cnt == 7'(baseband_cfg_pkg::ANT_DWELL_CYC - 1))
      begin
        d.dwell_cnt = 7'h00;
        d.rx_ant    = ~q.rx_ant;
      end
      else
        d.dwell_cnt = q.dwell_cnt + 7'h01;
    end
    if (HEADER_CRC_OK)
      d.good_ant = q.ant_sel;
    if (TRANSMIT_POWER_ENABLE)
      d.ant_sel = q.txc[baseband_cfg_pkg::TXC_DIV] ? q.good_ant : q.txc[baseband_cfg_pkg::TXC_ANT];
    else if (q.rxc[baseband_cfg_pkg::RXC_SINGLE])
      d.ant_sel = q.rxc[baseband_cfg_pkg::RXC_ANT];
    else
      d.ant_sel = q.rx_ant;

    // receive controls
    d.agc_freeze = q.rxc[baseband_cfg_pkg::RXC_FREEZE] & PACKET_ACTIVE;
    d.cir_clk    = q.trx[baseband_cfg_pkg::TRX_CONT_CLK] | !q.rxc[baseband_cfg_pkg::RXC_CIR_CLK]
                   | SIGNAL_DETECT;
    d.rx_clk     = q.trx[baseband_cfg_pkg::TRX_CONT_CLK] | RECEIVE_POWER_ENABLE;
    d.isi_en     = !q.rxc[baseband_cfg_pkg::RXC_ISI];
    d.ici_en     = !q.rxc[baseband_cfg_pkg::RXC_ICI];
    if (!PACKET_ACTIVE)
      d.rdy = 1'b0;
    else if (q.rxc[baseband_cfg_pkg::RXC_RDY_SFD] ? SFD_SEEN : HEADER_CRC_OK)
      d.rdy = 1'b1;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      q        <= '0;
      q.sig    <= baseband_cfg_pkg::RST_SIGNAL;
      q.svc    <= baseband_cfg_pkg::RST_SERVICE;
      q.len_hi <= baseband_cfg_pkg::RST_LEN_HI;
      q.len_lo <= baseband_cfg_pkg::RST_LEN_LO;
      q.txc    <= baseband_cfg_pkg::RST_TX_CFG;
      q.rxc    <= baseband_cfg_pkg::RST_RX_CFG;
      q.trx    <= baseband_cfg_pkg::RST_TRX_CFG;
    end
    else
      q <= d;
  end

  assign bus.rdata           = q.rdata;
  assign bus.rvalid          = q.rvalid;
  assign WEIGHT_SELECT       = q.weight;
  assign SHORT_PREAMBLE_MODE = q.short_pre;
  assign TX_RATE             = q.rate;
  assign TX_MODULATION       = q.modu;
  assign TX_CHIPS_PER_SYMBOL = q.chips;
  assign TX_LENGTH           = q.length;
  assign PREAMBLE_SYMBOLS    = q.pre_syms;
  assign CLEAR_CHANNEL       = q.cca;
  assign TX_TEST_ACTIVE      = q.test_on;
  assign TX_TEST_CHIP        = q.test_chip;
  assign ANTENNA_SELECT_OUT  = q.ant_sel;
  assign AGC_FREEZE          = q.agc_freeze;
  assign CIR_CLOCK_EN        = q.cir_clk;
  assign RX_CLOCK_EN         = q.rx_clk;
  assign ISI_EQ_EN           = q.isi_en;
  assign ICI_EQ_EN           = q.ici_en;
  assign RX_DATA_READY_OUT   = q.rdy;
  assign ACQ_DIVERSITY_ON    = q.div_on;

endmodule : baseband_txrx_config_regs

/* tb/baseband_txrx_config_regs_props.sv */
// concurrent checks on the control bus between controller and bank
`timescale 1ns/10ps
module baseband_txrx_config_regs_props
(
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rvalid
);
  logic [7:0] mem_q [64];
  logic [5:0] raddr_q;
  logic [1:0] rate_q;
  logic       mapped, sig_wr, svc_wr, txc_wr;
  assign mapped = raddr_q inside {[6'h0a:6'h16]} && !raddr_q[0];
  assign sig_wr = wr && addr == baseband_cfg_pkg::OFF_SIGNAL;
  assign svc_wr = wr && addr == baseband_cfg_pkg::OFF_SERVICE;
  assign txc_wr = wr && addr == baseband_cfg_pkg::OFF_TX_CFG;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // shadow of stored bytes
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      raddr_q <= 6'h00;
      rate_q  <= 2'h0;
      for (int i = 0; i < 64; i++)
        mem_q[i] <= 8'h00;
    end
    else
    begin
      if (rd)
        raddr_q <= addr;
      if (sig_wr)
        rate_q <= wdata[1:0];
      if (wr)
        mem_q[addr] <= wdata;
    end
  AST_READ_ANSWER: assert property (rd |=> rvalid) else $error("read not answered");
  AST_NO_STRAY: assert property (rvalid |-> $past(rd)) else $error("answer without read");
  AST_READ_BACK: assert property (rvalid |-> rdata == (mapped ? mem_q[raddr_q] : 8'h00))
    else $error("read data differs from stored byte");
  AST_DATA_HOLDS: assert property (!rvalid |-> $stable(rdata)) else $error("read data moved");
  AST_ONE_STROBE: assert property (!(wr && rd)) else $error("write and read together");
  AST_WR_PULSE: assert property (wr |=> !wr) else $error("write strobe too long");
  AST_SIG_ZERO: assert property (sig_wr |-> (wdata & baseband_cfg_pkg::SIG_ZERO_MASK) == 8'h00)
    else $error("unused signal bits nonzero");
  AST_SVC_MASK: assert property (svc_wr |-> (wdata & ~baseband_cfg_pkg::SVC_KEEP_MASK) == 8'h00)
    else $error("service bits outside mask");
  AST_TEST_RATE: assert property (txc_wr && rate_q != 2'h0 |-> !wdata[3])
    else $error("test enabled with nonzero rate");
  cover property (sig_wr);
  cover property (rvalid && !mapped);
  cover property (txc_wr && wdata[3]);
endmodule : baseband_txrx_config_regs_props

/* tb/baseband_txrx_config_regs_tb_top.sv */
// self-checking bench: controller and configuration bank back to back
`timescale 1ns/10ps
module baseband_txrx_config_regs_tb_top;
  logic                       MCLK, RST, cyc, stb, we, ack, obs_v, t0;
  logic                       ws, spm, cca, tact, tchip, ant, agc, circ, rxc, isi, ici, rdy, acq;
  logic [3:0]                 chips;
  logic [1:0]                 lrate;
  logic [7:0]                 adr, scnt, lcnt, v, w;
  logic [8:0]                 st, pre;
  logic [15:0]                len, obs, e;
  logic [31:0]                dat, dout, wbo;
  logic [15:0]                exp_q [$];
  baseband_cfg_pkg::rate_type rate;
  baseband_cfg_pkg::mod_type  modu;
  int                         seed, n_mismatch, compares, tcnt;
  baseband_cfg_if             cbus ();
  baseband_cfg_controller i_baseband_cfg_controller (.MCLK(MCLK), .RST(RST), .bus(cbus), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat), .WB_DAT_O(wbo), .WB_ACK_O(ack));
  baseband_txrx_config_regs i_baseband_txrx_config_regs (.MCLK(MCLK), .RST(RST), .bus(cbus), .ENERGY_DETECT(st[0]),
    .CARRIER_SENSE_PRIMARY(st[1]), .SIGNAL_QUALITY_PRIMARY(st[2]), .SIGNAL_DETECT(st[3]), .PACKET_ACTIVE(st[4]),
    .SFD_SEEN(st[5]), .HEADER_CRC_OK(st[6]), .TRANSMIT_POWER_ENABLE(st[7]), .RECEIVE_POWER_ENABLE(st[8]),
    .SHORT_PREAMBLE_COUNT(scnt), .LONG_PREAMBLE_COUNT(lcnt), .WEIGHT_SELECT(ws), .SHORT_PREAMBLE_MODE(spm),
    .TX_RATE(rate), .TX_MODULATION(modu), .TX_CHIPS_PER_SYMBOL(chips), .TX_LENGTH(len), .PREAMBLE_SYMBOLS(pre),
    .CLEAR_CHANNEL(cca), .TX_TEST_ACTIVE(tact), .TX_TEST_CHIP(tchip), .ANTENNA_SELECT_OUT(ant), .AGC_FREEZE(agc),
    .CIR_CLOCK_EN(circ), .RX_CLOCK_EN(rxc), .ISI_EQ_EN(isi), .ICI_EQ_EN(ici), .RX_DATA_READY_OUT(rdy),
    .ACQ_DIVERSITY_ON(acq));
  baseband_txrx_config_regs_props i_props (.MCLK(MCLK), .RST(RST), .addr(cbus.addr), .wdata(cbus.wdata),
    .wr(cbus.wr), .rd(cbus.rd), .rdata(cbus.rdata), .rvalid(cbus.rvalid));
  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic wb(input logic wen, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= wen;
    adr <= a;
    dat <= d;
    @(posedge MCLK);
    while (ack !== 1'b1)
      @(posedge MCLK);
    dout = wbo;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge MCLK);
  endtask : wb
  task automatic poll;
    do
      wb(1'b0, 8'h0c, 32'h0);
    while (dout[0] !== 1'b0);
  endtask : poll
  task automatic dw(input logic [7:0] o, input logic [7:0] d);
    wb(1'b1, 8'h00, {24'h0, o});
    wb(1'b1, 8'h04, {24'h0, d});
    wb(1'b1, 8'h08, 32'h1);
    poll();
    if (o == 8'h0a)
      lrate = d[1:0];
  endtask : dw
  task automatic ck(input logic [15:0] got, input logic [15:0] x);
    exp_q.push_back(x);
    obs   <= got;
    obs_v <= 1'b1;
    @(posedge MCLK);
    obs_v <= 1'b0;
    @(posedge MCLK);
  endtask : ck
  task automatic dr(input logic [7:0] o, input logic [7:0] x);
    wb(1'b1, 8'h00, {24'h0, o});
    wb(1'b1, 8'h08, 32'h2);
    poll();
    ck({8'h00, dout[15:8]}, {8'h00, x});
  endtask : dr
  function automatic logic [7:0] san(input logic [7:0] o, input logic [7:0] d);
    return o == 8'h0a ? d & 8'h1b : o == 8'h0c ? d & 8'h84 : o != 8'h12 ? d : d & (lrate == 2'h0 ? 8'hfe : 8'hf6);
  endfunction : san
  task give_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // clock, watcher, timeout, stimulus
  // ----------------------------------------
  initial
    forever #12.5 MCLK = ~MCLK;
  always @(posedge MCLK)
  begin
    tcnt++;
    if (obs_v === 1'b1)
    begin
      e = exp_q.pop_front();
      compares++;
      if (obs !== e)
        $display("wrong value at %0t: got %h expected %h", $time, obs, e);
      if (obs !== e)
        n_mismatch++;
    end
    if (tcnt == 40000)
      n_mismatch++;
    if (tcnt == 40000)
      give_verdict();
  end
  initial
  begin
    {MCLK, cyc, stb, we, obs_v, adr, dat, st, obs, lrate, RST} = 1;
    {scnt, lcnt} = 16'h8038;
    seed = 3113;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    repeat (2) @(posedge MCLK);
    ck({isi, ici, circ}, 3'h7);
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($random(seed));
      dw(8'h0a + 8'(2 * i), v);
      dr(8'h0a + 8'(2 * i), i == 7 ? 8'h00 : san(8'h0a + 8'(2 * i), v));
    end
    for (int r = 0; r < 4; r++)
    begin
      dw(8'h0a, {3'h0, r[0], r[1], 1'b0, r[1:0]});
      ck({ws, spm, 2'(rate), 2'(modu), chips}, {r[0], r[1], r[1:0], r > 1 ? 2'h2 : r[1:0], r > 1 ? 4'h8 : 4'hb});
    end
    scnt <= 8'($random(seed));
    lcnt <= 8'($random(seed));
    for (int m = 0; m < 3; m++)
    begin
      dw(8'h16, {3'h0, m[1], 4'h0});
      dw(8'h0a, {4'h0, m != 0, 3'h0});
      ck(pre, {8'h00, m == 1 ? scnt : lcnt} + 16'h0002);
    end
    v = 8'($random(seed));
    w = 8'($random(seed));
    dw(8'h0e, v);
    dw(8'h10, w);
    ck(len, {v, w});
    for (int k = 0; k < 32; k++)
    begin
      dw(8'h12, {1'b0, k[4:3], 5'h00});
      st <= {6'h00, k[2:0]};
      repeat (2) @(posedge MCLK);
      ck(cca, k[4] ? (k[3] ? k[0] | k[1] | k[2] : k[0] & (k[1] | k[2])) : (k[3] ? k[1] | k[2] : k[0]));
    end
    for (int k = 0; k < 6; k++)
    begin
      v = 8'($random(seed)) | 8'h01;
      w = 8'($random(seed)) & 8'h80;
      st <= 9'h000;
      dw(8'h14, v);
      dw(8'h16, w);
      st <= (9'($random(seed)) & 9'h108) | 9'h030;
      @(posedge MCLK);
      st[5] <= 1'b0;
      repeat (2) @(posedge MCLK);
      ck({agc, circ, rxc, isi, ici, rdy, ant, acq}, {v[7], w[7] | !v[6] | st[3], w[7] | st[8], !v[5], !v[4], v[3], v[1], 1'b0});
    end
    st <= 9'h080;
    dw(8'h0a, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      dw(8'h12, {3'h0, p[0], 1'b1, p[0], 2'h0});
      t0 = tchip;
      @(posedge MCLK);
      ck({tact, t0, tchip, ant}, {1'b1, p[0] ? 2'h3 : {t0, !t0}, p[0]});
    end
    dw(8'h16, 8'h08);
    st <= 9'h001;
    repeat (801) @(posedge MCLK);
    ck(cca, 16'h0001);
    give_verdict();
  end
endmodule : baseband_txrx_config_regs_tb_top
